// >>> include/psq_pkg.sv
// Shared types and constants of the process scheduler queues.
// Assumes one core clock; workspaces are named by small indices.
package psq_pkg;

    // ****************************************
    // Widths and timing
    // ****************************************
    localparam int WS_W             = 8;
    localparam int IP_W             = 32;
    localparam int CNT_W            = 16;
    localparam int SLICE_EXT_CYCLES = 5120;
    localparam int SLICE_LIMIT      = 2;
    localparam int SWITCH_MAX_NS    = 1000;
    localparam int CORE_PERIOD_NS   = 5;
    localparam int SWITCH_MAX_CYC   = SWITCH_MAX_NS / CORE_PERIOD_NS;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [WS_W-1:0] WS_RESET    = 8'h00;
    localparam logic [IP_W-1:0] IP_RESET    = 32'h0000_0000;
    localparam logic [1:0]      SLICE_RESET = 2'h0;

    // ****************************************
    // Commands and carriers
    // ****************************************
    typedef enum logic [2:0] {
        OP_START,
        OP_READY,
        OP_WAIT,
        OP_DPOINT,
        OP_ENDP,
        OP_SETJOIN
    } psq_op_type;

    typedef struct packed {
        psq_op_type      op;
        logic            pri;
        logic [WS_W-1:0] ws;
        logic [IP_W-1:0] ip;
        logic [CNT_W-1:0] cnt;
    } psq_cmd_type;

    typedef struct packed {
        logic            valid;
        logic            pri;
        logic [WS_W-1:0] ws;
        logic [IP_W-1:0] ip;
    } psq_run_type;

endpackage

// >>> rtl/psq_scheduler.sv
// Two-level ready-list scheduler with time slicing and join counters.
// Assumes the execution unit issues commands and runs what run_out names.
//
// Function
// - Each priority keeps a linked ready list with head and tail pointers.
// - Low priority runs only when no high process runs; a ready one preempts at the next descheduling point.
// - High priority processes are never time sliced.
// - Low process is forced off after two slices, at next descheduling point, when another low process is ready.
// - One slice is 5120 cycles of the external 5 MHz input clock.
// - Preemption and time-slice descheduling happen only on descheduling-point instructions.
// - Blocking process saves its instruction pointer, not the stack; next is taken.
// - A process switch completes in under one microsecond.
// - Start process appends the workspace to the tail of its priority list.
// - End process decrements the join counter; zero resumes parent, else deschedules.
// - Waiting processes stay off the ready lists and use no time.
// - A newly ready low process starts within 2n-2 slices, runs one to two.
// - Woken high process starts within 19 typical, 58 maximum cycles.
// - Interruptible long instructions bound high wake latency to 78 cycles.
`timescale 1ns/1ps
module psq_scheduler #(
    parameter int SLICE_EXT_CYCLES = psq_pkg::SLICE_EXT_CYCLES
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                arst_n,
    // External slice reference clock pin
    input  wire logic                ext_clk_pin,
    // Command channel from execution unit, links and timers
    input  wire logic                cmd_valid,
    input  wire psq_pkg::psq_cmd_type cmd_in,
    output logic                     cmd_ready,
    // Process to run
    output psq_pkg::psq_run_type     run_out,
    output logic                     run_load
);
    import psq_pkg::*;

    if (SLICE_EXT_CYCLES < 2) begin : g_slice_check
        $error("SLICE_EXT_CYCLES must be at least 2");
    end

    localparam int SC_W = $clog2(SLICE_EXT_CYCLES);
    localparam logic [SC_W-1:0] SC_LAST = SC_W'(SLICE_EXT_CYCLES - 1);
    localparam logic [1:0]      SL_MAX  = 2'(SLICE_LIMIT);

    typedef enum logic [1:0] {S_IDLE, S_RUN, S_PICK} psq_state_type;

    // ****************************************
    // State
    // ****************************************
    psq_state_type   state_reg, state_next;
    psq_run_type     run_reg, run_next, intr_reg, intr_next;
    logic            intr_valid_reg, intr_valid_next;
    logic [WS_W-1:0] high_queue_head_ptr_reg, low_queue_head_ptr_reg;
    logic [WS_W-1:0] high_queue_tail_ptr_reg, low_queue_tail_ptr_reg;
    logic [WS_W-1:0] head_cur [2];
    logic [WS_W-1:0] head_next [2];
    logic [WS_W-1:0] tail_cur [2];
    logic [WS_W-1:0] tail_next [2];
    logic [1:0]      full_reg, full_next;
    logic [1:0]      slices_reg, slices_next;
    logic            ready_reg, ready_next, load_reg, load_next;
    logic [SC_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic            sync1_reg, sync2_reg, prev_reg;

    // Workspace words kept on chip
    logic [WS_W-1:0]  link_mem [2**WS_W];
    logic [IP_W-1:0]  ip_mem   [2**WS_W];
    logic [CNT_W-1:0] cnt_mem  [2**WS_W];

    logic             link_we, ip_we, cnt_we;
    logic [WS_W-1:0]  link_addr, ip_addr, cnt_addr, link_data;
    logic [IP_W-1:0]  ip_data;
    logic [CNT_W-1:0] cnt_data;
    logic             enq_valid, enq_pri, slice_tick, take;
    logic [WS_W-1:0]  enq_ws;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next      = state_reg;
        run_next        = run_reg;
        intr_next       = intr_reg;
        intr_valid_next = intr_valid_reg;
        head_next       = head_cur;
        tail_next       = tail_cur;
        full_next       = full_reg;
        slices_next     = slices_reg;
        load_next       = 1'b0;
        link_we         = 1'b0;
        link_addr       = WS_RESET;
        link_data       = WS_RESET;
        ip_we           = 1'b0;
        ip_addr         = cmd_in.ws;
        ip_data         = cmd_in.ip;
        cnt_we          = 1'b0;
        cnt_addr        = cmd_in.ws;
        cnt_data        = cmd_in.cnt;
        enq_valid       = 1'b0;
        enq_pri         = cmd_in.pri;
        enq_ws          = cmd_in.ws;
        take            = cmd_valid && ready_reg;
        // Slice tick from external edges
        slice_tick    = sync2_reg && !prev_reg && (tick_cnt_reg == SC_LAST);
        tick_cnt_next = tick_cnt_reg;
        if (sync2_reg && !prev_reg) begin
            tick_cnt_next = slice_tick ? '0 : tick_cnt_reg + 1'b1;
        end
        if (slice_tick && run_reg.valid && run_reg.pri && slices_reg != SL_MAX) begin
            slices_next = slices_reg + 1'b1;
        end

        if (state_reg != S_PICK && take) begin
            case (cmd_in.op)
                OP_START: begin
                    ip_we     = 1'b1;
                    enq_valid = 1'b1;
                end
                OP_READY: begin
                    enq_valid = 1'b1;
                end
                OP_SETJOIN: begin
                    cnt_we = 1'b1;
                end
                OP_WAIT: begin
                    if (run_reg.valid) begin
                        ip_addr        = run_reg.ws;
                        ip_we          = 1'b1;
                        run_next.valid = 1'b0;
                        state_next     = S_PICK;
                    end
                end
                OP_DPOINT: begin
                    if (run_reg.valid && run_reg.pri && full_reg[0]) begin
                        intr_next       = run_reg;
                        intr_next.ip    = cmd_in.ip;
                        intr_valid_next = 1'b1;
                        run_next.valid  = 1'b0;
                        state_next      = S_PICK;
                    end else if (run_reg.valid && run_reg.pri && slices_reg == SL_MAX && full_reg[1]) begin
                        ip_addr        = run_reg.ws;
                        ip_we          = 1'b1;
                        enq_valid      = 1'b1;
                        enq_pri        = 1'b1;
                        enq_ws         = run_reg.ws;
                        run_next.valid = 1'b0;
                        state_next     = S_PICK;
                    end
                end
                OP_ENDP: begin
                    cnt_we   = 1'b1;
                    cnt_data = cnt_mem[cmd_in.ws] - 1'b1;
                    if (cnt_data == '0) begin
                        run_next.valid = 1'b1;
                        run_next.ws    = cmd_in.ws;
                        run_next.ip    = ip_mem[cmd_in.ws];
                        load_next      = 1'b1;
                    end else begin
                        run_next.valid = 1'b0;
                        state_next     = S_PICK;
                    end
                end
                default: begin
                end
            endcase
        end

        // Append to tail of a list
        if (enq_valid) begin
            if (full_reg[enq_pri]) begin
                link_we   = 1'b1;
                link_addr = tail_cur[enq_pri];
                link_data = enq_ws;
            end else begin
                head_next[enq_pri] = enq_ws;
                full_next[enq_pri] = 1'b1;
            end
            tail_next[enq_pri] = enq_ws;
        end

        if (state_reg == S_IDLE && (enq_valid || full_reg != 2'b00 || intr_valid_reg)) begin
            state_next = S_PICK;
        end else if (state_reg == S_RUN && !run_next.valid && state_next != S_PICK) begin
            state_next = S_IDLE;
        end else if (state_reg == S_IDLE && run_next.valid) begin
            state_next = S_RUN;
        end

        // Dispatch: high list, then interrupted low, then low list
        if (state_reg == S_PICK) begin
            load_next  = 1'b1;
            state_next = S_RUN;
            if (full_reg[0] || (!intr_valid_reg && full_reg[1])) begin
                enq_pri        = !full_reg[0];
                run_next.valid = 1'b1;
                run_next.pri   = enq_pri;
                run_next.ws    = head_cur[enq_pri];
                run_next.ip    = ip_mem[head_cur[enq_pri]];
                if (head_cur[enq_pri] == tail_cur[enq_pri]) begin
                    full_next[enq_pri] = 1'b0;
                end else begin
                    head_next[enq_pri] = link_mem[head_cur[enq_pri]];
                end
                if (enq_pri) begin
                    slices_next = SLICE_RESET;
                end
            end else if (intr_valid_reg) begin
                run_next        = intr_reg;
                intr_valid_next = 1'b0;
            end else begin
                load_next  = 1'b0;
                state_next = S_IDLE;
            end
        end
        ready_next = (state_next != S_PICK);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg      <= S_IDLE;
            run_reg        <= '0;
            intr_reg       <= '0;
            intr_valid_reg <= 1'b0;
            high_queue_head_ptr_reg <= WS_RESET;
            low_queue_head_ptr_reg  <= WS_RESET;
            high_queue_tail_ptr_reg <= WS_RESET;
            low_queue_tail_ptr_reg  <= WS_RESET;
            full_reg       <= 2'h0;
            slices_reg     <= SLICE_RESET;
            ready_reg      <= 1'b0;
            load_reg       <= 1'b0;
            tick_cnt_reg   <= '0;
            sync1_reg      <= 1'b0;
            sync2_reg      <= 1'b0;
            prev_reg       <= 1'b0;
        end else begin
            state_reg      <= state_next;
            run_reg        <= run_next;
            intr_reg       <= intr_next;
            intr_valid_reg <= intr_valid_next;
            high_queue_head_ptr_reg <= head_next[0];
            low_queue_head_ptr_reg  <= head_next[1];
            high_queue_tail_ptr_reg <= tail_next[0];
            low_queue_tail_ptr_reg  <= tail_next[1];
            full_reg       <= full_next;
            slices_reg     <= slices_next;
            ready_reg      <= ready_next;
            load_reg       <= load_next;
            tick_cnt_reg   <= tick_cnt_next;
            sync1_reg      <= ext_clk_pin;
            sync2_reg      <= sync1_reg;
            prev_reg       <= sync2_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (link_we) begin
            link_mem[link_addr] <= link_data;
        end
        if (ip_we) begin
            ip_mem[ip_addr] <= ip_data;
        end
        if (cnt_we) begin
            cnt_mem[cnt_addr] <= cnt_data;
        end
    end

    // List pointers indexed by priority
    assign head_cur  = '{high_queue_head_ptr_reg, low_queue_head_ptr_reg};
    assign tail_cur  = '{high_queue_tail_ptr_reg, low_queue_tail_ptr_reg};
    assign cmd_ready = ready_reg;
    assign run_out   = run_reg;
    assign run_load  = load_reg;

endmodule

// >>> tb/psq_exec_model.sv
// Execution unit model: external slice clock, running process tracking.
// Assumes the scheduler's registered dispatch outputs.
`timescale 1ns/1ps
module psq_exec_model (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    // Dispatch side
    input  wire psq_pkg::psq_run_type run_out,
    input  wire logic                 run_load,
    // Slice reference and running workspace
    output logic                      ext_clk_pin,
    output logic [psq_pkg::WS_W-1:0]  cur_ws
);
    import psq_pkg::*;
    // Free running 5 MHz reference
    initial begin
        ext_clk_pin = 1'b0;
        forever #100 ext_clk_pin = ~ext_clk_pin;
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ws <= WS_RESET;
        end else if (run_load) begin
            cur_ws <= run_out.ws;
        end
    end
endmodule

// >>> tb/psq_scheduler_properties.sv
// Port checker of the process scheduler queues.
// Assumes binding onto psq_scheduler; one clock domain.
`timescale 1ns/1ps
module psq_scheduler_properties #(
    parameter int SLICE_EXT_CYCLES = psq_pkg::SLICE_EXT_CYCLES
) (
    input wire logic                  core_clk,
    input wire logic                  arst_n,
    input wire logic                  ext_clk_pin,
    input wire logic                  cmd_valid,
    input wire psq_pkg::psq_cmd_type  cmd_in,
    input wire logic                  cmd_ready,
    input wire psq_pkg::psq_run_type  run_out,
    input wire logic                  run_load
);
    import psq_pkg::*;
    // ****************************************
    // Dispatch and handshake properties
    // ****************************************
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic take;
    assign take = cmd_valid && cmd_ready;
    property p_load_pulse; run_load |=> !run_load; endproperty
    property p_load_valid; run_load |-> run_out.valid; endproperty
    property p_pick_one; $fell(cmd_ready) |=> cmd_ready; endproperty
    property p_start_idle;
        take && cmd_in.op == OP_START && !run_out.valid |-> ##2 run_load && run_out.ws == $past(cmd_in.ws, 2)
            && run_out.pri == $past(cmd_in.pri, 2) && run_out.ip == $past(cmd_in.ip, 2);
    endproperty
    property p_wait_off; take && cmd_in.op == OP_WAIT && run_out.valid |=> !run_out.valid; endproperty
    property p_wait_time; take && cmd_in.op == OP_WAIT && run_out.valid |=> !cmd_ready ##1 cmd_ready; endproperty
    property p_high_kept;
        run_out.valid && !run_out.pri && !$past(take) && !(take && cmd_in.op inside {OP_WAIT, OP_ENDP})
            |=> $stable(run_out);
    endproperty
    property p_quiet_stable; run_out.valid && cmd_ready && !cmd_valid && !$past(take) |=> $stable(run_out); endproperty
    a_load_pulse: assert property (p_load_pulse)
        else $error("dispatch pulse longer than one cycle");
    a_load_valid: assert property (p_load_valid)
        else $error("dispatch pulse without a valid process");
    a_pick_one: assert property (p_pick_one)
        else $error("command channel blocked over one cycle");
    a_start_idle: assert property (p_start_idle)
        else $error("started process not dispatched two cycles later");
    a_wait_off: assert property (p_wait_off)
        else $error("waiting process still shown as running");
    a_wait_time: assert property (p_wait_time)
        else $error("switch after wait not done in two cycles");
    a_high_kept: assert property (p_high_kept)
        else $error("high priority process displaced without waiting");
    a_quiet_stable: assert property (p_quiet_stable)
        else $error("running process changed with no command");
    c_start: cover property (take && cmd_in.op == OP_START);
    c_low_load: cover property (run_load && run_out.pri);
    c_endp: cover property (take && cmd_in.op == OP_ENDP);
endmodule
bind psq_scheduler psq_scheduler_properties #(.SLICE_EXT_CYCLES(SLICE_EXT_CYCLES)) u_props (
    .core_clk(core_clk), .arst_n(arst_n), .ext_clk_pin(ext_clk_pin), .cmd_valid(cmd_valid),
    .cmd_in(cmd_in), .cmd_ready(cmd_ready), .run_out(run_out), .run_load(run_load));

// >>> tb/test_psq_scheduler.sv
// Self-checking bench of the process scheduler queues.
// Assumes package, design, checker and execution model compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_psq_scheduler;
    import psq_pkg::*;
    localparam int SLICE = 8;
    // Two slices of 40 core cycles per reference edge, plus sync margin
    localparam int SLICE_WAIT = 2 * SLICE * 40 + 60;
    typedef struct packed { psq_cmd_type c; psq_run_type r; } psq_row_type;
    logic            core_clk, arst_n, ext_clk_pin, cmd_valid, cmd_ready, run_load;
    psq_cmd_type     cmd_in;
    psq_run_type     run_out;
    logic [WS_W-1:0] cur_ws;
    int              n_fail, samples_checked;
    psq_row_type     rows [14];
    psq_scheduler #(.SLICE_EXT_CYCLES(SLICE)) dut (.core_clk(core_clk), .arst_n(arst_n), .ext_clk_pin(ext_clk_pin),
        .cmd_valid(cmd_valid), .cmd_in(cmd_in), .cmd_ready(cmd_ready), .run_out(run_out), .run_load(run_load));
    psq_exec_model u_model (.core_clk(core_clk), .arst_n(arst_n), .run_out(run_out), .run_load(run_load),
        .ext_clk_pin(ext_clk_pin), .cur_ws(cur_ws));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic psq_row_type row(psq_op_type o, logic p, logic [WS_W-1:0] w, logic [IP_W-1:0] i,
                                        logic [CNT_W-1:0] n, logic ep, logic [WS_W-1:0] ew, logic [IP_W-1:0] ei);
        return '{'{o, p, w, i, n}, '{1'b1, ep, ew, ei}};
    endfunction
    task automatic issue(input psq_cmd_type c);
        int n;
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_in <= c;
        do @(posedge core_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        @(posedge core_clk);
        #1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < SWITCH_MAX_CYC) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK(cmd_ready, 1'b1)
    endtask
    task automatic run_row(input psq_row_type x);
        issue(x.c);
        `CHK(run_out, x.r)
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Tests need about 1500 cycles
    initial begin
        #60us;
        n_fail++;
        report_and_stop();
    end
    initial begin
        arst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_in = '0;
        rows = '{row(OP_START, 1'b1, 8'h05, 32'h100, 16'h0, 1'b1, 8'h05, 32'h100),
                 row(OP_START, 1'b1, 8'h06, 32'h200, 16'h0, 1'b1, 8'h05, 32'h100),
                 row(OP_WAIT, 1'b1, 8'h00, 32'h110, 16'h0, 1'b1, 8'h06, 32'h200),
                 row(OP_READY, 1'b1, 8'h05, 32'h0, 16'h0, 1'b1, 8'h06, 32'h200),
                 row(OP_START, 1'b0, 8'h09, 32'h300, 16'h0, 1'b1, 8'h06, 32'h200),
                 row(OP_DPOINT, 1'b1, 8'h00, 32'h210, 16'h0, 1'b0, 8'h09, 32'h300),
                 row(OP_SETJOIN, 1'b0, 8'h09, 32'h0, 16'h2, 1'b0, 8'h09, 32'h300),
                 row(OP_START, 1'b0, 8'h0f, 32'h400, 16'h0, 1'b0, 8'h09, 32'h300),
                 row(OP_START, 1'b0, 8'h10, 32'h500, 16'h0, 1'b0, 8'h09, 32'h300),
                 row(OP_WAIT, 1'b0, 8'h00, 32'h310, 16'h0, 1'b0, 8'h0f, 32'h400),
                 row(OP_ENDP, 1'b0, 8'h09, 32'h0, 16'h0, 1'b0, 8'h10, 32'h500),
                 row(OP_ENDP, 1'b0, 8'h09, 32'h0, 16'h0, 1'b0, 8'h09, 32'h310),
                 row(OP_WAIT, 1'b0, 8'h00, 32'h320, 16'h0, 1'b1, 8'h06, 32'h210),
                 row(OP_DPOINT, 1'b1, 8'h00, 32'h220, 16'h0, 1'b1, 8'h06, 32'h210)};
        repeat (8) @(posedge core_clk);
        `CHK(run_out, '0)
        arst_n <= 1'b1;
        foreach (rows[k]) run_row(rows[k]);
        repeat (SLICE_WAIT) @(posedge core_clk);
        run_row(row(OP_DPOINT, 1'b1, 8'h00, 32'h230, 16'h0, 1'b1, 8'h05, 32'h110));
        run_row(row(OP_DPOINT, 1'b1, 8'h00, 32'h240, 16'h0, 1'b1, 8'h05, 32'h110));
        repeat (SLICE_WAIT) @(posedge core_clk);
        run_row(row(OP_DPOINT, 1'b1, 8'h00, 32'h250, 16'h0, 1'b1, 8'h06, 32'h230));
        @(posedge core_clk);
        arst_n <= 1'b0;
        #1;
        `CHK(run_out, '0)
        `CHK(run_load, 1'b0)
        `CHK(cmd_ready, 1'b0)
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        issue('{OP_WAIT, 1'b0, 8'h00, 32'h600, 16'h0});
        `CHK(run_out.valid, 1'b0)
        run_row(row(OP_START, 1'b0, 8'h07, 32'h700, 16'h0, 1'b0, 8'h07, 32'h700));
        repeat (2) @(posedge core_clk);
        `CHK(cur_ws, 8'h07)
        report_and_stop();
    end
endmodule
